/* dv/tcbf_pin_model.sv */
// Far-side model: drives the capture pin and a free-running slow clock
`timescale 1ns/1ps
module tcbf_pin_model (
	input wire aclk,
	output logic capture_input_pin,
	output logic low_freq_clock
);
	// ------------------------------------------------------------
	// Slow clock runs free, phase unrelated to aclk
	// ------------------------------------------------------------
	initial begin
		capture_input_pin = 1'b0;
		low_freq_clock = 1'b0;
		forever #30.5 low_freq_clock = ~low_freq_clock;
	end
	// Hold the pin at a level for a number of aclk cycles
	task automatic drive(input logic v, input int n);
		begin
			capture_input_pin <= v;
			repeat (n) @(posedge aclk);
		end
	endtask
endmodule // tcbf_pin_model

/* dv/tcbf_props.sv */
// Checker for bus handshakes, pulses and filter edges at the timer ports
`timescale 1ns/1ps
module tcbf_props (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire capture_input_pin,
	input wire filtered_input,
	input wire toggle_match,
	input wire timer_irq
);
	// ------------------------------------------------------------
	// Assertions, all in the aclk domain
	// ------------------------------------------------------------
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
	a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
	a_read_answers: assert property (s_axi_arvalid && s_axi_arready |->
		##[1:2] s_axi_rvalid) else $error("read answer late");
	a_read_blocks: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("arready while rvalid");
	a_write_blocks: assert property (s_axi_bvalid |->
		!s_axi_awready && !s_axi_wready) else $error("write ready early");
	a_write_slverr: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready && s_axi_awaddr[31:5] != 27'h0 |->
		##[1:3] s_axi_bvalid && s_axi_bresp == 2'h2)
		else $error("unmapped write not refused");
	a_read_slverr: assert property (s_axi_arvalid && s_axi_arready &&
		s_axi_araddr[31:5] != 27'h0 |-> ##[1:2] s_axi_rvalid &&
		s_axi_rresp == 2'h2) else $error("unmapped read not refused");
	a_toggle_pulse: assert property (toggle_match |=> !toggle_match)
		else $error("toggle pulse too long");
	// Last agreeing sample saw the pin four cycles before the rise
	a_filter_rise: assert property (
		$rose(filtered_input) |-> $past(capture_input_pin, 4))
		else $error("filter rose without high pin");
	// Main scenarios reached
	cover property (toggle_match);
	cover property ($rose(filtered_input));
	cover property ($rose(timer_irq));
endmodule // tcbf_props

/* dv/tcbf_tb.sv */
// Testbench: register bus tasks and scenarios for the timer block
`timescale 1ns/1ps
`include "tcbf_regs.vh"
module tb;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic capture_input_pin, low_freq_clock, timer_irq;
	logic filtered_input, toggle_match;
	logic [7:0] rd_val;
	int err_count, samples_checked, cyc, ta, tb_, tc, i;
	int ivs [4] = '{1, 2, 4, 256};
	tcbf_timer tcbf_timer_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capture_input_pin,
		.low_freq_clock, .timer_irq, .filtered_input, .toggle_match);
	tcbf_pin_model tcbf_pin_model_i (.aclk, .capture_input_pin,
		.low_freq_clock);
	// ------------------------------------------------------------
	// Clock and cycle stamp
	// ------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	always @(posedge aclk) cyc <= cyc + 1;
	// ------------------------------------------------------------
	// Checking and closing
	// ------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		begin
			samples_checked++;
			if (seen !== exp) begin
				err_count++;
				$display("Error %0t: saw %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task automatic report_and_stop;
		begin
			$display("Checks %0d mismatches %0d", samples_checked, err_count);
			if (err_count == 0 && samples_checked > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	// A bounded wait ran out
	task automatic tmo;
		begin
			err_count++;
			report_and_stop();
		end
	endtask
	// ------------------------------------------------------------
	// Bus tasks: byte address is the word index times four
	// ------------------------------------------------------------
	task automatic wr(input logic [3:0] idx, input logic [7:0] d);
		int n;
		begin
			@(posedge aclk);
			s_axi_awaddr <= {26'h0, idx, 2'h0};
			s_axi_wdata <= {24'h0, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			for (n = 0; n < 50; n++) begin
				@(posedge aclk);
				if (s_axi_awready) s_axi_awvalid <= 1'b0;
				if (s_axi_wready) s_axi_wvalid <= 1'b0;
				if (s_axi_bvalid) break;
			end
			rsp = s_axi_bresp;
			s_axi_bready <= 1'b0;
			if (n == 50) tmo();
		end
	endtask
	task automatic rd(input logic [3:0] idx);
		int n;
		begin
			@(posedge aclk);
			s_axi_araddr <= {26'h0, idx, 2'h0};
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			for (n = 0; n < 50; n++) begin
				@(posedge aclk);
				if (s_axi_arready) s_axi_arvalid <= 1'b0;
				if (s_axi_rvalid) break;
			end
			rd_val = s_axi_rdata[7:0];
			rsp = s_axi_rresp;
			s_axi_rready <= 1'b0;
			if (n == 50) tmo();
		end
	endtask
	task automatic rdchk(input logic [3:0] idx, input logic [7:0] exp);
		begin
			rd(idx);
			check(rd_val, exp);
		end
	endtask
	// Low byte then high byte, as software must load a compare value
	task automatic set_per(input logic [7:0] lo);
		begin
			wr(`TCBF_OFF_PER_LO, lo);
			wr(`TCBF_OFF_PER_HI, 8'h00);
		end
	endtask
	// Cycle stamp of the next toggle pulse
	task automatic wait_tog(output int t);
		int n;
		begin
			n = 0;
			do begin
				@(posedge aclk);
				n++;
			end while (toggle_match !== 1'b1 && n < 70000);
			if (n >= 70000) tmo();
			t = cyc;
		end
	endtask
	// Filter: settle, reject a one-sample glitch, then a held change
	task automatic filt(input logic [1:0] nc, input int iv);
		begin
			wr(`TCBF_OFF_CTRL, {4'h2, nc, 2'h0});
			tcbf_pin_model_i.drive(1'b1, 4 * iv + 8);
			check(filtered_input, 1'b1);
			tcbf_pin_model_i.drive(1'b0, iv);
			tcbf_pin_model_i.drive(1'b1, 2 * iv + 8);
			check(filtered_input, 1'b1);
			tcbf_pin_model_i.drive(1'b0, 2 * iv);
			check(filtered_input, 1'b1);
			tcbf_pin_model_i.drive(1'b0, 2 * iv + 8);
			check(filtered_input, 1'b0);
		end
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		s_axi_wstrb = 4'hf;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		rdchk(`TCBF_OFF_PER_HI, 8'hff);
		rdchk(`TCBF_OFF_CTRL, 8'h00);
		// Shared holding byte and paired commit
		wr(`TCBF_OFF_PER_LO, 8'h40);
		rdchk(`TCBF_OFF_PER_LO, 8'hff);
		wr(`TCBF_OFF_TOG_HI, 8'h00);
		rdchk(`TCBF_OFF_TOG_LO, 8'h40);
		wr(`TCBF_OFF_PER_HI, 8'h00);
		rdchk(`TCBF_OFF_PER_LO, 8'h40);
		wr(`TCBF_OFF_TOG_LO, 8'h10);
		wr(`TCBF_OFF_TOG_HI, 8'h00);
		// Buffered path, stopped then running
		wr(`TCBF_OFF_MASK, 8'h00);
		wr(`TCBF_OFF_CTRL, 8'h02);
		set_per(8'h50);
		wr(`TCBF_OFF_CTRL, 8'h03);
		wait_tog(ta);
		wait_tog(tb_);
		check(tb_ - ta, 81);
		check(timer_irq, 1'b0);
		wr(`TCBF_OFF_MASK, 8'h01);
		wait_tog(ta);
		set_per(8'h20);
		rdchk(`TCBF_OFF_PER_LO, 8'h20);
		wait_tog(tb_);
		wait_tog(tc);
		check(tb_ - ta, 81);
		check(tc - tb_, 33);
		check(timer_irq, 1'b1);
		wr(`TCBF_OFF_CTRL, 8'h00);
		rdchk(`TCBF_OFF_STAT, 8'h03);
		repeat (3) @(posedge aclk);
		check(timer_irq, 1'b0);
		rdchk(`TCBF_OFF_STAT, 8'h00);
		// Direct path: immediate update, then a value below the count
		wr(`TCBF_OFF_CTRL, 8'h01);
		wait_tog(ta);
		set_per(8'h40);
		wait_tog(tb_);
		check(tb_ - ta, 65);
		set_per(8'h12);
		wait_tog(tc);
		check(tc - tb_, 65536);
		wr(`TCBF_OFF_CTRL, 8'h00);
		// Unmapped places are refused
		wr(4'h9, 8'h01);
		check(rsp, 2'h2);
		rd(4'hc);
		check(rsp, 2'h2);
		// Filter modes with the timer stopped
		for (i = 0; i < 4; i++) filt(i[1:0], ivs[i]);
		rdchk(`TCBF_OFF_STAT, 8'h07);
		// Slow mode: slow clock sampling, then a blocked pin
		wr(`TCBF_OFF_CTRL, 8'h3c);
		tcbf_pin_model_i.drive(1'b1, 400);
		check(filtered_input, 1'b1);
		wr(`TCBF_OFF_CTRL, 8'h34);
		tcbf_pin_model_i.drive(1'b1, 20);
		check(filtered_input, 1'b0);
		// Filter select is frozen while running
		wr(`TCBF_OFF_CTRL, 8'h2d);
		wr(`TCBF_OFF_CTRL, 8'h25);
		rd(`TCBF_OFF_CTRL);
		check(rd_val[3:2], 2'h3);
		wr(`TCBF_OFF_CTRL, 8'h00);
		report_and_stop();
	end
endmodule // tb
bind tcbf_timer tcbf_props tcbf_props_i (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .capture_input_pin, .filtered_input,
	.toggle_match, .timer_irq);

/* hdl/tcbf_filter.v */
// Digital noise filter for the capture input pin
`timescale 1ns/1ps
module tcbf_filter (
	input wire aclk,
	input wire aresetn,
	input wire pin_sync,
	input wire [1:0] nc_sel,
	input wire slow_mode,
	input wire lf_tick,
	output reg filt_out
);
`include "tcbf_regs.vh"
	// Prescaler, sample counter and previous sample
	reg [8:0] div_reg;
	reg [1:0] agree_reg;
	reg samp_reg;
	reg [8:0] period;
	reg tick;
	reg blocked;
	// --------------------------------------------------------------
	// Interval select
	// --------------------------------------------------------------
	always @* begin
		period = `TCBF_NC_DIV1;
		tick = 1'b0;
		blocked = 1'b0;
		case (nc_sel)
		2'h1: period = `TCBF_NC_DIV1;
		2'h2: period = `TCBF_NC_DIV2;
		2'h3: period = `TCBF_NC_DIV3;
		default: period = `TCBF_NC_DIV1;
		endcase
		if (slow_mode) begin
			// Low-speed: 11 uses low clock /2, 01 and 10 block pin
			tick = (nc_sel == 2'h3) & lf_tick;
			blocked = (nc_sel == 2'h1) | (nc_sel == 2'h2);
		end else begin
			tick = (div_reg == period - 9'h001);
		end
	end
	// --------------------------------------------------------------
	// Sampling and three-sample agreement
	// --------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			div_reg <= 9'h000;
			agree_reg <= 2'h0;
			samp_reg <= 1'b0;
			filt_out <= 1'b0;
		end else if (nc_sel == 2'h0) begin
			// Bypass: pass the pin through
			div_reg <= 9'h000;
			agree_reg <= 2'h0;
			samp_reg <= pin_sync;
			filt_out <= pin_sync;
		end else if (blocked) begin
			div_reg <= 9'h000;
			agree_reg <= 2'h0;
			filt_out <= 1'b0;
		end else begin
			// Runs regardless of the run bit
			div_reg <= tick ? 9'h000 : div_reg + 9'h001;
			if (tick) begin
				samp_reg <= pin_sync;
				if (pin_sync == filt_out) begin
					agree_reg <= 2'h0;
				end else if (pin_sync != samp_reg) begin
					agree_reg <= 2'h1;
				end else if (agree_reg == `TCBF_NC_AGREE - 2'h1) begin
					filt_out <= pin_sync;
					agree_reg <= 2'h0;
				end else begin
					agree_reg <= agree_reg + 2'h1;
				end
			end
		end
	end
endmodule // tcbf_filter

/* hdl/tcbf_regs.vh */
// Register offsets, field positions and timing counts for the timer block
`ifndef TCBF_REGS_VH
`define TCBF_REGS_VH
// ----------------------------------------------------------------------
// Register word indices (byte address is the index times four)
// ----------------------------------------------------------------------
`define TCBF_OFF_CTRL 4'h0
`define TCBF_OFF_PER_LO 4'h1
`define TCBF_OFF_PER_HI 4'h2
`define TCBF_OFF_TOG_LO 4'h3
`define TCBF_OFF_TOG_HI 4'h4
`define TCBF_OFF_CNT 4'h5
`define TCBF_OFF_STAT 4'h6
`define TCBF_OFF_MASK 4'h7
// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define TCBF_CTRL_RUN 0
`define TCBF_CTRL_DBF 1
`define TCBF_CTRL_NC_LO 2
`define TCBF_CTRL_NC_HI 3
`define TCBF_CTRL_SLOW 4
`define TCBF_CTRL_CAPEN 5
// ----------------------------------------------------------------------
// Status fields and reset values
// ----------------------------------------------------------------------
`define TCBF_ST_PMATCH 0
`define TCBF_ST_TMATCH 1
`define TCBF_ST_EDGE 2
`define TCBF_ST_W 3
`define TCBF_CMP_RST 16'hffff
// ----------------------------------------------------------------------
// Noise filter sampling intervals in gear-clock cycles
// ----------------------------------------------------------------------
`define TCBF_NC_DIV1 9'h002
`define TCBF_NC_DIV2 9'h004
`define TCBF_NC_DIV3 9'h100
`define TCBF_NC_AGREE 2'h3
`endif

/* hdl/tcbf_timer.v */
// Timer compare-register write path, double buffer and input filter top
// Functional notes
// - Low-byte write only fills shared holding byte
// - High-byte write commits high plus held low
// - Buffer-enable bit chooses direct or double
// - Running with buffer: writes land in buffer
// - Period match sets status (irq if masked in), loads buffer
// - Buffered reads return the last written value
// - Stopped with buffer: both copies update
// - Unbuffered high write updates active at once
// - Low new value: counter wraps before match
// - Filter feeds capture modes instead of pin
// - Output changes after three equal samples
// - Nonzero select runs filter regardless of run
// - Filter-select writes ignored while running
// - Select codes give intervals 2, 4, 256
// - Low-speed: 11 uses slow/2, 01 and 10 block
//
// The AXI4-Lite interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module tcbf_timer (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire capture_input_pin,
	input wire low_freq_clock,
	output reg timer_irq,
	output reg filtered_input,
	output reg toggle_match
);
`include "tcbf_regs.vh"
	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	reg [31:0] awaddr_reg; // Latched write address
	reg aw_have_reg; // Write address held
	reg [31:0] wdata_reg; // Latched write data
	reg [3:0] wstrb_reg; // Latched strobes
	reg w_have_reg; // Write data held
	reg [7:0] hold_low_reg; // Shared low-byte holding buffer
	reg [15:0] per_act_reg; // Active period compare
	reg [15:0] tog_act_reg; // Active toggle compare
	reg [15:0] per_dbf_reg; // Period double buffer
	reg [15:0] tog_dbf_reg; // Toggle double buffer
	reg [15:0] cnt_reg; // Up counter
	reg run_reg; // Run bit
	reg dbf_reg; // Buffer-enable bit
	reg [1:0] nc_reg; // Filter select field
	reg slow_reg; // Low-speed mode select
	reg capen_reg; // Capture mode uses the pin
	reg [`TCBF_ST_W-1:0] stat_reg; // Sticky events
	reg [`TCBF_ST_W-1:0] mask_reg; // Interrupt mask
	reg pin_s1_reg; // Pin synchroniser stage 1
	reg pin_s2_reg; // Pin synchroniser stage 2
	reg lf_s1_reg; // Slow clock synchroniser stage 1
	reg lf_s2_reg; // Slow clock synchroniser stage 2
	reg lf_s3_reg; // Slow clock edge history
	reg lf_half_reg; // Divide-by-two of slow clock
	reg filt_d_reg; // Filtered level history
	wire filt_lvl; // Filter output
	wire wr_fire; // Write commits this cycle
	wire [3:0] waddr; // Write word index
	wire [3:0] raddr; // Read word index
	wire wr_lane; // Low lane strobed
	wire per_hit; // Counter equals period
	wire tog_hit; // Counter equals toggle
	wire lf_tick; // Slow/2 sample pulse
	wire edge_evt; // Filtered edge seen
	wire [`TCBF_ST_W-1:0] evt; // Events this cycle
	wire rd_stat; // Status read accepted
	wire wr_ok; // Write address lies in the register page
	wire rd_ok; // Read address lies in the register page
	wire in_lvl; // Level fed to the timer
	reg [31:0] rdata_next; // Read mux
	// --------------------------------------------------------------
	// Address decode, match taps and events
	// --------------------------------------------------------------
	// A write commits once both halves are held and no answer waits
	assign wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
	// Word index selects the register; the low two bits are ignored
	assign waddr = awaddr_reg[5:2];
	assign raddr = s_axi_araddr[5:2];
	// Set upper bits mean an unmapped place, so nothing may change
	assign wr_ok = (awaddr_reg[31:6] == 26'h0);
	assign rd_ok = (s_axi_araddr[31:6] == 26'h0);
	// Register writes travel in the lowest byte lane only
	assign wr_lane = wstrb_reg[0];
	// Matches only count while the timer runs
	assign per_hit = run_reg & (cnt_reg == per_act_reg);
	assign tog_hit = run_reg & (cnt_reg == tog_act_reg);
	// Every second rising edge of the synchronised slow clock
	assign lf_tick = lf_s2_reg & ~lf_s3_reg & lf_half_reg;
	// Timer sees the filtered level only in capture modes
	assign in_lvl = capen_reg ? filt_lvl : 1'b0;
	// Any change of the filtered level in a capture mode is an edge event
	assign edge_evt = capen_reg & (filt_lvl != filt_d_reg);
	assign evt = {edge_evt, tog_hit, per_hit};
	// Only a mapped status read clears the sticky bits
	assign rd_stat = s_axi_arvalid & s_axi_arready & rd_ok &
		(raddr == `TCBF_OFF_STAT);
	// --------------------------------------------------------------
	// Input synchronisers and slow clock divider
	// --------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			pin_s1_reg <= 1'b0;
			pin_s2_reg <= 1'b0;
			lf_s1_reg <= 1'b0;
			lf_s2_reg <= 1'b0;
			lf_s3_reg <= 1'b0;
			lf_half_reg <= 1'b0;
			filt_d_reg <= 1'b0;
		end else begin
			// Two flops on each outside input before logic reads it
			pin_s1_reg <= capture_input_pin;
			pin_s2_reg <= pin_s1_reg;
			lf_s1_reg <= low_freq_clock;
			lf_s2_reg <= lf_s1_reg;
			lf_s3_reg <= lf_s2_reg;
			filt_d_reg <= filt_lvl;
			// Every other rising slow-clock edge
			if (lf_s2_reg & ~lf_s3_reg) begin
				lf_half_reg <= ~lf_half_reg;
			end
		end
	end
	// --------------------------------------------------------------
	// Noise filter
	// --------------------------------------------------------------
	tcbf_filter tcbf_filter_i (
		.aclk(aclk),
		.aresetn(aresetn),
		.pin_sync(pin_s2_reg),
		.nc_sel(nc_reg),
		.slow_mode(slow_reg),
		.lf_tick(lf_tick),
		.filt_out(filt_lvl)
	);
	// --------------------------------------------------------------
	// Write channel capture, either order
	// --------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 32'h00000000;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			// Readies pulse while idle; a held half or an answer blocks
			s_axi_awready <= ~aw_have_reg & ~s_axi_awready & ~s_axi_bvalid;
			s_axi_wready <= ~w_have_reg & ~s_axi_wready & ~s_axi_bvalid;
			// Address half taken
			if (s_axi_awvalid & s_axi_awready) begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			// Data half taken
			if (s_axi_wvalid & s_axi_wready) begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			// Both halves held: commit and raise the answer
			if (wr_fire) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Unmapped offsets answer with a slave error
				s_axi_bresp <= (waddr > `TCBF_OFF_MASK ||
					awaddr_reg[31:6] != 26'h0) ? 2'h2 : 2'h0;
			end else if (s_axi_bvalid & s_axi_bready) begin
				// Answer taken by the master
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// --------------------------------------------------------------
	// Compare registers, control, counter
	// --------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			hold_low_reg <= 8'h00;
			per_act_reg <= `TCBF_CMP_RST;
			tog_act_reg <= `TCBF_CMP_RST;
			per_dbf_reg <= `TCBF_CMP_RST;
			tog_dbf_reg <= `TCBF_CMP_RST;
			cnt_reg <= 16'h0000;
			run_reg <= 1'b0;
			dbf_reg <= 1'b0;
			nc_reg <= 2'h0;
			slow_reg <= 1'b0;
			capen_reg <= 1'b0;
			mask_reg <= {`TCBF_ST_W{1'b0}};
		end else begin
			// Counter clears on period match; overshoot wraps
			if (!run_reg) begin
				// Stopped timer rests at zero
				cnt_reg <= 16'h0000;
			end else if (per_hit) begin
				// Period match restarts the count
				cnt_reg <= 16'h0000;
			end else begin
				cnt_reg <= cnt_reg + 16'h0001;
			end
			// Buffered values become active on period match
			if (dbf_reg & per_hit) begin
				per_act_reg <= per_dbf_reg;
				tog_act_reg <= tog_dbf_reg;
			end
			// Mapped low-lane writes only; unmapped places change nothing
			if (wr_fire & wr_lane & wr_ok) begin
				case (waddr)
				`TCBF_OFF_CTRL: begin
					// Run, buffer, slow and capture bits are always writable
					run_reg <= wdata_reg[`TCBF_CTRL_RUN];
					dbf_reg <= wdata_reg[`TCBF_CTRL_DBF];
					slow_reg <= wdata_reg[`TCBF_CTRL_SLOW];
					capen_reg <= wdata_reg[`TCBF_CTRL_CAPEN];
					if (!run_reg) begin
						nc_reg <= wdata_reg[`TCBF_CTRL_NC_HI:`TCBF_CTRL_NC_LO];
					end
				end
				`TCBF_OFF_PER_LO, `TCBF_OFF_TOG_LO: begin
					hold_low_reg <= wdata_reg[7:0];
				end
				`TCBF_OFF_PER_HI: begin
					per_dbf_reg <= {wdata_reg[7:0], hold_low_reg};
					if (!dbf_reg || !run_reg) begin
						per_act_reg <= {wdata_reg[7:0], hold_low_reg};
					end // else
				end
				`TCBF_OFF_TOG_HI: begin
					tog_dbf_reg <= {wdata_reg[7:0], hold_low_reg};
					if (!dbf_reg || !run_reg) begin
						tog_act_reg <= {wdata_reg[7:0], hold_low_reg};
					end // else
				end
				`TCBF_OFF_MASK: begin
					mask_reg <= wdata_reg[`TCBF_ST_W-1:0];
				end
				default: begin
					// Read-only or unmapped: no effect
				end
				endcase
			end
		end
	end
	// --------------------------------------------------------------
	// Sticky status, interrupt and output flops
	// --------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			stat_reg <= {`TCBF_ST_W{1'b0}};
			timer_irq <= 1'b0;
			filtered_input <= 1'b0;
			toggle_match <= 1'b0;
		end else begin
			// New events win over the read clear
			stat_reg <= (rd_stat ? {`TCBF_ST_W{1'b0}} : stat_reg) | evt;
			// Interrupt follows the next status value, never lagging a set
			timer_irq <= |(((rd_stat ? {`TCBF_ST_W{1'b0}} : stat_reg) | evt)
				& mask_reg);
			filtered_input <= in_lvl;
			toggle_match <= tog_hit;
		end
	end
	// --------------------------------------------------------------
	// Read mux
	// --------------------------------------------------------------
	always @* begin
		// Unused bits and places read as zero
		rdata_next = 32'h00000000;
		case (raddr)
		`TCBF_OFF_CTRL: rdata_next[5:0] = {capen_reg, slow_reg, nc_reg,
			dbf_reg, run_reg};
		// Buffered reads show the last written value
		`TCBF_OFF_PER_LO: rdata_next[7:0] = dbf_reg ? per_dbf_reg[7:0] :
			per_act_reg[7:0];
		`TCBF_OFF_PER_HI: rdata_next[7:0] = dbf_reg ? per_dbf_reg[15:8] :
			per_act_reg[15:8];
		`TCBF_OFF_TOG_LO: rdata_next[7:0] = dbf_reg ? tog_dbf_reg[7:0] :
			tog_act_reg[7:0];
		`TCBF_OFF_TOG_HI: rdata_next[7:0] = dbf_reg ? tog_dbf_reg[15:8] :
			tog_act_reg[15:8];
		`TCBF_OFF_CNT: rdata_next[15:0] = cnt_reg;
		`TCBF_OFF_STAT: rdata_next[`TCBF_ST_W-1:0] = stat_reg;
		`TCBF_OFF_MASK: rdata_next[`TCBF_ST_W-1:0] = mask_reg;
		default: rdata_next = 32'h00000000;
		endcase
	end
	// --------------------------------------------------------------
	// Read channel
	// --------------------------------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= 2'h0;
		end else begin
			// Ready pulses while idle and stays low while an answer waits
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
			if (s_axi_arvalid & s_axi_arready) begin
				// Address taken: data and response stand from next cycle
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdata_next;
				s_axi_rresp <= (raddr > `TCBF_OFF_MASK ||
					s_axi_araddr[31:6] != 26'h0) ? 2'h2 : 2'h0;
			end else if (s_axi_rvalid & s_axi_rready) begin
				// Answer taken by the master
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // tcbf_timer
